// [design/serial_alert_port.sv]
// four-wire serial slave port, register map and open-drain limit alert
`timescale 1ns/1ps
module serial_alert_port
  import serial_alert_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe_n,
  // open-drain alert pin
  output logic alert_o,
  output logic alert_oe_n,
  // measurement results, same clock
  input wire logic meas_valid,
  input wire logic [2:0] meas_chan,
  input wire logic [7:0] meas_value,
  // alert response from the two-wire engine, same clock
  input wire logic ara_req,
  input wire logic ara_lost,
  input wire logic [6:0] dev_addr,
  output logic ara_reply_valid,
  output logic [7:0] ara_reply_byte,
  // status
  output logic four_wire_locked,
  output logic two_wire_mode
);

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic din_s1;
    logic din_s2;
    spi_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [6:0] ptr;
    logic dout;
    logic [1:0] cs_rises;
    logic locked;
    logic [63:0][7:0] mem;
    logic [NUM_CH-1:0] status;
    logic [NUM_CH-1:0] read_seen;
    logic [NUM_CH-1:0] out_lim;
    logic reply_valid;
    logic [7:0] reply_byte;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // next writable address after p, wrapping inside the map
  function automatic logic [6:0] next_writable(input logic [6:0] p);
    logic [5:0] cand;
    logic found;
    next_writable = PTR_FIRST;
    found = 1'b0;
    for (int i = 1; i <= 64; i++) begin
      cand = 6'(p[5:0] + 6'(i));
      if (!found && WRITABLE_MASK[cand]) begin
        next_writable = {1'b0, cand};
        found = 1'b1;
      end
    end
  endfunction : next_writable

  function automatic logic [6:0] next_seq(input logic [6:0] p);
    next_seq = (p[5:0] == PTR_LAST[5:0]) ? PTR_FIRST : {1'b0, 6'(p[5:0] + 6'h01)};
  endfunction : next_seq

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_data;
  logic alert_active;
  logic [NUM_CH-1:0] status_vis;

  // edges seen only on the second and third stages
  assign cs_low = ~s_reg.cs_sync[1];
  assign cs_fall = s_reg.cs_sync[2] & ~s_reg.cs_sync[1];
  assign cs_rise = ~s_reg.cs_sync[2] & s_reg.cs_sync[1];
  assign sclk_rise = ~s_reg.sclk_sync[2] & s_reg.sclk_sync[1];
  assign sclk_fall = s_reg.sclk_sync[2] & ~s_reg.sclk_sync[1];
  assign rx_byte = {s_reg.rx_shift[6:0], s_reg.din_s2};
  assign byte_done = sclk_rise && (s_reg.bit_cnt == 3'h7);
  assign status_vis = s_reg.status;

  always_comb begin
    rd_data = s_reg.mem[s_reg.ptr[5:0]];
    if (s_reg.ptr == LOCK_ADDR) begin
      rd_data = 8'h00;
      rd_data[LOCK_BIT] = s_reg.locked;
    end else if (s_reg.ptr[5:0] == STAT1_ADDR) begin
      rd_data = {4'h0, status_vis[STAT1_CH-1:0]};
    end else if (s_reg.ptr[5:0] == STAT2_ADDR) begin
      rd_data = {5'h00, status_vis[NUM_CH-1:STAT1_CH]};
    end
  end

  always_comb begin
    s_next = s_reg;
    // serial clock only sampled, never driven
    s_next.cs_sync = {s_reg.cs_sync[1:0], cs_n};
    s_next.sclk_sync = {s_reg.sclk_sync[1:0], sclk};
    s_next.din_s1 = din;
    s_next.din_s2 = s_reg.din_s1;
    s_next.reply_valid = 1'b0;

    // lock on third chip select rise
    if (cs_rise && !s_reg.locked) begin
      s_next.cs_rises = 2'(s_reg.cs_rises + 2'h1);
      if (s_reg.cs_rises == LOCK_PULSES - 2'h1) begin
        s_next.locked = 1'b1;
      end
    end

    if (sclk_rise) begin
      s_next.rx_shift = rx_byte;
      s_next.bit_cnt = 3'(s_reg.bit_cnt + 3'h1);
    end
    // output bits change on falling edge
    if (sclk_fall) begin
      s_next.dout = s_reg.tx_shift[7];
      s_next.tx_shift = {s_reg.tx_shift[6:0], 1'b0};
    end

    case (s_reg.state)
      ST_IDLE: begin
        // accept only after chip select falls
        if (cs_fall && s_reg.locked) begin
          s_next.state = ST_CMD;
          s_next.bit_cnt = 3'h0;
          s_next.tx_shift = 8'h00;
        end
      end
      ST_CMD: begin
        if (byte_done) begin
          if (rx_byte == CMD_WRITE) begin
            s_next.state = ST_ADDR;
          end else if (rx_byte == CMD_READ) begin
            s_next.state = ST_RDATA;
            s_next.tx_shift = rd_data;
            s_next.ptr = next_seq(s_reg.ptr);
          end else begin
            s_next.state = ST_SKIP;
          end
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          s_next.ptr = (rx_byte[6:0] == LOCK_ADDR) ? LOCK_ADDR : {1'b0, rx_byte[5:0]};
          s_next.state = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (byte_done) begin
          if (s_reg.ptr != LOCK_ADDR && WRITABLE_MASK[s_reg.ptr[5:0]]) begin
            s_next.mem[s_reg.ptr[5:0]] = rx_byte;
          end
          s_next.ptr = next_writable(s_reg.ptr);
        end
      end
      ST_RDATA: begin
        if (byte_done) begin
          s_next.tx_shift = rd_data;
          s_next.ptr = next_seq(s_reg.ptr);
        end
      end
      ST_SKIP: begin
        s_next.state = ST_SKIP;
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    // chip select rise drops any partial byte
    if (cs_rise) begin
      s_next.state = ST_IDLE;
      s_next.bit_cnt = 3'h0;
    end

    // status read noted when a status byte is loaded for shifting
    if (s_reg.state == ST_RDATA || (s_reg.state == ST_CMD && rx_byte == CMD_READ)) begin
      if (byte_done && s_reg.ptr[6] == 1'b0) begin
        if (s_reg.ptr[5:0] == STAT1_ADDR) begin
          s_next.read_seen[STAT1_CH-1:0] = '1;
        end else if (s_reg.ptr[5:0] == STAT2_ADDR) begin
          s_next.read_seen[NUM_CH-1:STAT1_CH] = '1;
        end
      end
    end

    if (meas_valid && meas_chan < 3'(NUM_CH)) begin
      s_next.out_lim[meas_chan] =
        (meas_value > s_reg.mem[UPPER_BASE + 6'(meas_chan)]) ||
        (meas_value < s_reg.mem[LOWER_BASE + 6'(meas_chan)]);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // clear only when back in limits and status read
      if (s_reg.status[c] && s_reg.read_seen[c] && !s_next.out_lim[c]) begin
        s_next.status[c] = 1'b0;
        s_next.read_seen[c] = 1'b0;
      end
      if (meas_valid && meas_chan == 3'(c) && s_next.out_lim[c]) begin
        s_next.status[c] = 1'b1;
        s_next.read_seen[c] = 1'b0;
      end
    end

    // alert response: own address with lsb 1
    // lost arbitration means a lower address answered
    if (ara_req && alert_active && !ara_lost) begin
      s_next.reply_valid = 1'b1;
      s_next.reply_byte = {dev_addr, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.cs_sync <= 3'h7;
      s_reg.state <= ST_IDLE;
      for (int i = 0; i < NUM_CH; i++) begin
        s_reg.mem[UPPER_BASE + 6'(i)] <= UPPER_RESET;
        s_reg.mem[LOWER_BASE + 6'(i)] <= LOWER_RESET;
      end
      s_reg.mem[CFG1_ADDR] <= CFG1_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // any sticky limit event raises the alert
  assign alert_active = |s_reg.status;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // output released unless a transaction is open
  assign dout_o = s_reg.dout;
  assign dout_oe_n = !(cs_low && s_reg.state != ST_IDLE);
  // open drain: only ever pulls low
  assign alert_o = 1'b0;
  // polarity picks the active level, disable releases the pin
  // pin follows status, so with active-low polarity it releases once status clears
  assign alert_oe_n = s_reg.mem[CFG1_ADDR][ALERT_DISABLE_BIT] |
    (s_reg.mem[CFG1_ADDR][ALERT_POLARITY_BIT] ? alert_active : !alert_active);
  assign ara_reply_valid = s_reg.reply_valid;
  assign ara_reply_byte = s_reg.reply_byte;
  assign four_wire_locked = s_reg.locked;
  // alert doubles as bus alert while two-wire is selected
  assign two_wire_mode = !s_reg.locked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // chip select seen high at the pin for the sync depth must leave dout released
  a_dout_released: assert property (cs_n [*3] |-> dout_oe_n)
    else $error("dout driven while chip select high");
  a_lock_sticky: assert property (s_reg.locked |=> s_reg.locked)
    else $error("lock bit fell");
  // the first byte of a read is loaded at the end of the command byte
  a_ptr_wrap: assert property (byte_done && s_reg.ptr == PTR_LAST &&
    (s_reg.state == ST_RDATA || (s_reg.state == ST_CMD && rx_byte == CMD_READ))
    |=> s_reg.ptr == PTR_FIRST)
    else $error("pointer did not wrap");
  a_idle_ignores: assert property (s_reg.state == ST_IDLE && !cs_fall
    |=> s_reg.state == ST_IDLE)
    else $error("left idle without chip select fall");
  a_partial_drop: assert property (cs_rise |=> s_reg.state == ST_IDLE &&
    $stable(s_reg.mem))
    else $error("partial byte changed registers");
  a_dout_falls: assert property (!sclk_fall && s_reg.state != ST_IDLE
    |=> $stable(dout_o))
    else $error("dout changed off a falling edge");
  a_alert_default: assert property (alert_active &&
    s_reg.mem[CFG1_ADDR][6:5] == 2'b00 |-> !alert_oe_n)
    else $error("active low alert not pulled");
  a_alert_disable: assert property (s_reg.mem[CFG1_ADDR][ALERT_DISABLE_BIT]
    |-> alert_oe_n)
    else $error("disabled alert still pulling");
  a_status_hold: assert property ($fell(s_reg.status[0]) |->
    $past(s_reg.read_seen[0]) && !s_reg.out_lim[0])
    else $error("status cleared without read");
  a_ara_reply: assert property (ara_req && alert_active && !ara_lost
    |=> ara_reply_valid && ara_reply_byte[0])
    else $error("no alert response reply");
  a_readonly_kept: assert property (s_reg.state == ST_WDATA && byte_done
    |=> $stable(s_reg.mem[STAT1_ADDR]))
    else $error("read-only register written");

  c_lock: cover property ($rose(s_reg.locked));
  c_read_byte: cover property (s_reg.state == ST_RDATA && byte_done);
  c_write_byte: cover property (s_reg.state == ST_WDATA && byte_done);
  c_ara: cover property (ara_reply_valid);

endmodule : serial_alert_port

// [include/serial_alert_pkg.sv]
// constants for the serial slave port with limit alert
package serial_alert_pkg;
  // command words
  localparam logic [7:0] CMD_WRITE = 8'h90;
  localparam logic [7:0] CMD_READ = 8'h91;
  // pointer range and lock status address
  localparam logic [6:0] PTR_FIRST = 7'h00;
  localparam logic [6:0] PTR_LAST = 7'h3F;
  localparam logic [6:0] LOCK_ADDR = 7'h7F;
  localparam int LOCK_BIT = 0;
  localparam logic [1:0] LOCK_PULSES = 2'h3;
  // register addresses inside the 64-byte map
  localparam logic [5:0] STAT1_ADDR = 6'h00;
  localparam logic [5:0] STAT2_ADDR = 6'h01;
  localparam logic [5:0] CFG1_ADDR = 6'h18;
  localparam logic [5:0] UPPER_BASE = 6'h20;
  localparam logic [5:0] LOWER_BASE = 6'h28;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] UPPER_RESET = 8'hFF;
  localparam logic [7:0] LOWER_RESET = 8'h00;
  // config1 fields
  localparam int ALERT_POLARITY_BIT = 6;
  localparam int ALERT_DISABLE_BIT = 5;
  // channels: internal temp, external temp, supply, four analog inputs
  localparam int NUM_CH = 7;
  localparam int STAT1_CH = 4;
  // bit 1 = register accepts serial writes; status registers are read-only
  localparam logic [63:0] WRITABLE_MASK = 64'hFFFF_FFFF_FFFF_FFFC;
  // serial clock period in the bench and system clock period, in ns
  localparam int SCLK_PERIOD_NS = 400;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  // front-end states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_SKIP = 6'b100000
  } spi_state_t;
endpackage : serial_alert_pkg

// [tb/serial_alert_port_tb_top.sv]
// self-checking bench for the serial slave port with limit alert
`timescale 1ns/1ps
module serial_alert_port_tb_top;
  import serial_alert_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_oe_n;
  logic alert_o;
  logic alert_oe_n;
  logic meas_valid;
  logic [2:0] meas_chan;
  logic [7:0] meas_value;
  logic ara_req;
  logic ara_lost;
  logic [6:0] dev_addr;
  logic ara_reply_valid;
  logic [7:0] ara_reply_byte;
  logic four_wire_locked;
  logic two_wire_mode;
  wire dout_line = dout_oe_n ? 1'h1 : dout_o;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [23:0] v;

  always #25 clk = ~clk;

  serial_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_line(dout_line));

  serial_alert_port u_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .meas_valid(meas_valid), .meas_chan(meas_chan),
    .meas_value(meas_value), .ara_req(ara_req), .ara_lost(ara_lost),
    .dev_addr(dev_addr), .ara_reply_valid(ara_reply_valid),
    .ara_reply_byte(ara_reply_byte), .four_wire_locked(four_wire_locked),
    .two_wire_mode(two_wire_mode));

  // ----------------------------------------
  // compare, access and closing tasks
  // ----------------------------------------
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic [31:0] rx;
    host.frame({CMD_WRITE, a, d}, 16 + 8 * n, rx);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int n);
    logic [31:0] rx;
    host.frame({CMD_WRITE, a, 16'h0000}, 16, rx);
    host.frame({CMD_READ, 24'h000000}, 8 + 8 * n, rx);
    v = rx[23:0];
  endtask : rd

  task automatic meas(input logic [2:0] ch, input logic [7:0] val);
    meas_chan = ch;
    meas_value = val;
    meas_valid = 1'h1;
    host.wait_clk(1);
    meas_valid = 1'h0;
    host.wait_clk(2);
  endtask : meas

  // a reply pulse is looked for on each of the three edges after the request
  task automatic ara(input logic lost, input logic exp);
    logic seen;
    seen = 1'h0;
    ara_lost = lost;
    ara_req = 1'h1;
    repeat (3) begin
      host.wait_clk(1);
      ara_req = 1'h0;
      seen = seen | ara_reply_valid;
    end
    check_bit("ara reply", exp, seen);
    if (exp) check_byte("ara byte", {dev_addr, 1'h1}, ara_reply_byte);
    // one free edge so a following request does not reassign the strobe in this step
    host.wait_clk(1);
  endtask : ara

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_lock();
    check_bit("oe idle", 1'h1, dout_oe_n);
    check_bit("alert idle", 1'h1, alert_oe_n);
    check_bit("two wire", 1'h1, two_wire_mode);
    wr(8'h05, 16'h5A00, 1);
    check_bit("early lock", 1'h0, four_wire_locked);
    host.pulses(2);
    check_bit("locked", 1'h1, four_wire_locked);
    rd(8'h7F, 1);
    check_bit("lock bit", 1'h1, v[LOCK_BIT]);
    rd(8'h05, 1);
    check_byte("pre-lock write", 8'h00, v[7:0]);
  endtask : t_reset_lock

  task automatic t_wrap();
    wr(8'h3F, 16'hA1B2, 2);
    rd(8'h3F, 3);
    check_byte("wrap read", 8'hA1, v[23:16]);
    check_byte("wrap to 00", 8'h00, v[15:8]);
    check_byte("read 01", 8'h00, v[7:0]);
    rd(8'h02, 1);
    check_byte("skip read-only", 8'hB2, v[7:0]);
    check_bit("oe after frame", 1'h1, dout_oe_n);
  endtask : t_wrap

  task automatic t_partial();
    logic [31:0] rx;
    host.frame({CMD_WRITE, 8'h06, 8'hC3, 8'h00}, 20, rx);
    rd(8'h06, 1);
    check_byte("partial byte", 8'h00, v[7:0]);
    host.frame({8'h55, 8'h06, 8'hEE, 8'h00}, 24, rx);
    rd(8'h06, 1);
    check_byte("unknown command", 8'h00, v[7:0]);
  endtask : t_partial

  task automatic t_alert();
    wr(8'h20, 16'h4040, 2);
    meas(3'h0, 8'h50);
    meas(3'h1, 8'h50);
    check_bit("alert on", 1'h0, alert_oe_n);
    check_bit("alert drive", 1'h0, alert_o);
    ara(1'h0, 1'h1);
    ara(1'h1, 1'h0);
    meas(3'h0, 8'h10);
    meas(3'h1, 8'h10);
    check_bit("alert held", 1'h0, alert_oe_n);
    dev_addr = 7'h31;
    ara(1'h0, 1'h1);
    rd(8'h00, 1);
    check_byte("status1", 8'h03, v[7:0]);
    check_bit("alert off", 1'h1, alert_oe_n);
    // lower limit of channel 4 sits at 2C; its flag lives in the second status register
    wr(8'h2C, 16'h2000, 1);
    meas(3'h4, 8'h10);
    check_bit("alert low limit", 1'h0, alert_oe_n);
    rd(8'h01, 1);
    check_byte("status2", 8'h01, v[7:0]);
    meas(3'h4, 8'h30);
    check_bit("alert off 2", 1'h1, alert_oe_n);
  endtask : t_alert

  task automatic t_config();
    wr(8'h18, 16'h4000, 1);
    check_bit("active high idle", 1'h0, alert_oe_n);
    wr(8'h18, 16'h6000, 1);
    check_bit("disabled", 1'h1, alert_oe_n);
    wr(8'h18, 16'h0000, 1);
    check_bit("enabled low", 1'h1, alert_oe_n);
  endtask : t_config

  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    meas_valid = 1'h0;
    meas_chan = 3'h0;
    meas_value = 8'h00;
    ara_req = 1'h0;
    ara_lost = 1'h0;
    // own address for the alert reply; value is arbitrary
    dev_addr = 7'h2A;
    host.wait_clk(3);
    arst_n = 1'h1;
    host.wait_clk(4);
    t_reset_lock();
    t_wrap();
    t_partial();
    t_alert();
    t_config();
    finish_test();
  end
endmodule : serial_alert_port_tb_top

// [tb/serial_host_model.sv]
// host serial master model that drives the four-wire slave port
`timescale 1ns/1ps
module serial_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout_line
);
  // idle levels: clock parked low, data lines pulled up
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wait_clk

  task automatic pulses(input int n);
    repeat (n) begin
      cs_n = 1'h0;
      wait_clk(8);
      cs_n = 1'h1;
      wait_clk(8);
    end
  endtask : pulses

  task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'h0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      din = tx[31-i];
      wait_clk(4);
      rx = {rx[30:0], dout_line};
      sclk = 1'h1;
      wait_clk(4);
      sclk = 1'h0;
    end
    wait_clk(4);
    cs_n = 1'h1;
    din = 1'h1;
    wait_clk(8);
  endtask : frame
endmodule : serial_host_model
